// >>> bench/i2c_bus_partner.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Open-drain bus lines with pull-ups, shared with other devices
// ************************************************************
module i2c_bus_partner
(
    input wire logic i_scl_oe,
    input wire logic i_sda_oe,
    input wire logic i_peer_scl_low,
    input wire logic i_peer_sda_low,
    output logic o_scl_line,
    output logic o_sda_line
);
    // Released lines float to the pull-up level, never to the last driven value
    assign o_scl_line = !(i_scl_oe || i_peer_scl_low);
    assign o_sda_line = !(i_sda_oe || i_peer_sda_low);
endmodule : i2c_bus_partner

`default_nettype wire

// >>> bench/i2c_control_mode_clock_select_tb.sv
`timescale 1ns/1ps
`default_nettype none

module i2c_control_mode_clock_select_tb;
    import i2c_ctl_pkg::*;

    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr_en = 1'b0;
    logic i_rd_en = 1'b0;
    logic i_arb_lost = 1'b0;
    logic i_rx_data_read = 1'b0;
    logic i_scl_hold_low = 1'b0;
    logic i_sda_drive_low = 1'b0;
    logic [7:0] o_rdata;
    logic o_bus_drive;
    logic [1:0] o_mode;
    logic o_reception_start;
    logic o_reception_refused;
    logic o_scl_tick;
    logic o_scl_oe;
    logic o_sda_oe;
    logic scl_o;
    logic sda_o;
    logic scl_line;
    logic sda_line;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    // Divisor rows: select code beside the serial clock period it must give
    logic [8:0] div_rows [16] = '{9'h01c, 9'h028, 9'h030, 9'h040, 9'h0a8, 9'h064, 9'h070,
        9'h080, 9'h038, 9'h050, 9'h060, 9'h080, 9'h150, 9'h0c8, 9'h0e0, 9'h100};

    i2c_control_mode_clock_select i_dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
        .o_rdata(o_rdata), .i_arb_lost(i_arb_lost), .i_rx_data_read(i_rx_data_read),
        .i_scl_hold_low(i_scl_hold_low), .i_sda_drive_low(i_sda_drive_low),
        .o_bus_drive(o_bus_drive), .o_mode(o_mode), .o_reception_start(o_reception_start),
        .o_reception_refused(o_reception_refused), .o_scl_tick(o_scl_tick),
        .o_scl_o(scl_o), .o_scl_oe(o_scl_oe), .o_sda_o(sda_o), .o_sda_oe(o_sda_oe));

    i2c_bus_partner i_bus (.i_scl_oe(o_scl_oe), .i_sda_oe(o_sda_oe),
        .i_peer_scl_low(1'b0), .i_peer_sda_low(1'b0),
        .o_scl_line(scl_line), .o_sda_line(sda_line));

    initial
    begin
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr_en <= 1'b1;
        @(posedge i_clk_sys);
        i_wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd_en <= 1'b1;
        @(posedge i_clk_sys);
        i_rd_en <= 1'b0;
        #1;
        chk(16'(o_rdata), 16'(exp));
    endtask : rd

    task automatic pulse(input bit arb);
        @(posedge i_clk_sys);
        if (arb) i_arb_lost <= 1'b1;
        else i_rx_data_read <= 1'b1;
        @(posedge i_clk_sys);
        i_arb_lost <= 1'b0;
        i_rx_data_read <= 1'b0;
        #1;
    endtask : pulse

    // Cycles to the next serial clock tick, 600 when none comes
    task automatic wait_tick(output int k);
        k = 0;
        do
        begin
            @(posedge i_clk_sys);
            #1;
            k++;
        end while (o_scl_tick !== 1'b1 && k < 600);
    endtask : wait_tick

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    always @(posedge i_clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        repeat (8) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        rd(8'h00, 8'h00);
        chk(16'({o_mode, o_bus_drive, o_scl_oe, o_sda_oe, scl_o, sda_o}), 16'h0000);
        // Divisor table, one row per select code, halted between rows
        for (int c = 0; c < 16; c++)
        begin
            // Odd codes run in master receive, even ones in master transmit
            wr(8'h00, (((c % 2) != 0) ? 8'ha0 : 8'hb0) | 8'(c));
            wait_tick(n);
            wait_tick(n);
            chk(16'(n), 16'(div_rows[c]));
            wr(8'h00, 8'h00);
        end
        // Mode pair decode for every code
        for (int m = 0; m < 4; m++)
        begin
            wr(8'h00, 8'(m << 4));
            #1;
            chk(16'(o_mode), 16'(m));
        end
        wait_tick(n);
        chk(16'(n), 16'd600);
        wr(8'h00, 8'h83);
        wait_tick(n);
        chk(16'(n), 16'd600);
        wr(8'h00, 8'hb0);
        pulse(1'b1);
        chk(16'(o_mode), 16'h0000);
        wr(8'h00, 8'h90);
        pulse(1'b1);
        chk(16'(o_mode), 16'h0001);
        // Receive-data reads: enabled, disabled, halted and transmit mode
        wr(8'h00, 8'h80);
        pulse(1'b0);
        chk(16'({o_reception_start, o_reception_refused}), 16'h0002);
        wr(8'h00, 8'hc0);
        pulse(1'b0);
        chk(16'({o_reception_start, o_reception_refused}), 16'h0001);
        wr(8'h00, 8'h40);
        pulse(1'b0);
        chk(16'({o_reception_start, o_reception_refused}), 16'h0000);
        wr(8'h00, 8'h90);
        pulse(1'b0);
        chk(16'({o_reception_start, o_reception_refused}), 16'h0000);
        // Halted module must leave both lines to the pull-ups
        wr(8'h00, 8'h00);
        i_scl_hold_low <= 1'b1;
        i_sda_drive_low <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        #1;
        chk(16'({o_bus_drive, scl_line, sda_line, scl_o, sda_o}), 16'h000c);
        wr(8'h00, 8'h80);
        repeat (2) @(posedge i_clk_sys);
        #1;
        chk(16'({o_bus_drive, scl_line, sda_line, scl_o, sda_o}), 16'h0010);
        i_scl_hold_low <= 1'b0;
        i_sda_drive_low <= 1'b0;
        // Read-back, unmapped place, mid-run reset
        wr(8'h00, 8'h5a);
        wr(8'h04, 8'hff);
        rd(8'h00, 8'h5a);
        rd(8'h04, 8'h00);
        @(posedge i_clk_sys);
        i_reset_n <= 1'b0;
        repeat (8) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        rd(8'h00, 8'h00);
        chk(16'({o_mode, o_bus_drive, o_scl_oe, o_sda_oe, scl_o, sda_o}), 16'h0000);
        wrap_up();
    end
endmodule : i2c_control_mode_clock_select_tb

`default_nettype wire

// >>> logic/i2c_control_mode_clock_select.sv
`timescale 1ns/1ps
`default_nettype none

module i2c_control_mode_clock_select
    import i2c_ctl_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [7:0] o_rdata,
    input wire logic i_arb_lost,
    input wire logic i_rx_data_read,
    input wire logic i_scl_hold_low,
    input wire logic i_sda_drive_low,
    output logic o_bus_drive,
    output logic [1:0] o_mode,
    output logic o_reception_start,
    output logic o_reception_refused,
    output logic o_scl_tick,
    output logic o_scl_o,
    output logic o_scl_oe,
    output logic o_sda_o,
    output logic o_sda_oe
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [8:0] clock_divisor(input logic [3:0] code);
        clock_divisor = DIVISOR_TABLE[code];
    endfunction : clock_divisor

    logic interface_enable;
    logic next_reception_disable;
    logic master_slave_select;
    logic transmit_receive_select;
    logic [3:0] clock_select;
    logic ctl_write;
    logic ctl_read;
    logic run;
    logic [8:0] divisor;
    logic [8:0] half_divisor;
    logic [8:0] count;
    scl_phase_t phase;

    assign ctl_write = i_wr_en && (i_addr == BUS_CONTROL_A_OFFSET);
    assign ctl_read = i_rd_en && (i_addr == BUS_CONTROL_A_OFFSET);
    assign run = interface_enable && master_slave_select;
    assign divisor = clock_divisor(clock_select);
    assign half_divisor = {1'b0, divisor[8:1]};
    assign o_mode = {master_slave_select, transmit_receive_select};

    // ************************************************************
    // Control register fields
    // ************************************************************
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            interface_enable <= BUS_CONTROL_A_RESET[INTERFACE_ENABLE_POS];
            next_reception_disable <= BUS_CONTROL_A_RESET[NEXT_RECEPTION_DISABLE_POS];
            clock_select <= BUS_CONTROL_A_RESET[CLOCK_SELECT_MSB:CLOCK_SELECT_LSB];
        end
        else if (ctl_write)
        begin
            interface_enable <= i_wdata[INTERFACE_ENABLE_POS];
            next_reception_disable <= i_wdata[NEXT_RECEPTION_DISABLE_POS];
            clock_select <= i_wdata[CLOCK_SELECT_MSB:CLOCK_SELECT_LSB];
        end
    end

    // Arbitration loss beats a software write in the same cycle: the bus
    // has already been handed over, so master mode must not be re-entered.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            master_slave_select <= BUS_CONTROL_A_RESET[MASTER_SLAVE_SELECT_POS];
            transmit_receive_select <= BUS_CONTROL_A_RESET[TRANSMIT_RECEIVE_SELECT_POS];
        end
        else if (i_arb_lost && master_slave_select)
        begin
            master_slave_select <= 1'b0;
            transmit_receive_select <= 1'b0;
        end
        else if (ctl_write)
        begin
            master_slave_select <= i_wdata[MASTER_SLAVE_SELECT_POS];
            transmit_receive_select <= i_wdata[TRANSMIT_RECEIVE_SELECT_POS];
        end
    end

    // ************************************************************
    // Register read port
    // ************************************************************
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            o_rdata <= 8'h00;
        end
        else if (ctl_read)
        begin
            o_rdata <= {interface_enable, next_reception_disable, master_slave_select,
                        transmit_receive_select, clock_select};
        end
        else
        begin
            o_rdata <= 8'h00;
        end
    end

    // ************************************************************
    // Next reception after a receive-data read
    // ************************************************************
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            o_reception_start <= 1'b0;
            o_reception_refused <= 1'b0;
        end
        else
        begin
            o_reception_start <= interface_enable && !transmit_receive_select
                && i_rx_data_read && !next_reception_disable;
            o_reception_refused <= interface_enable && !transmit_receive_select
                && i_rx_data_read && next_reception_disable;
        end
    end

    // ************************************************************
    // Serial clock divider
    // ************************************************************
    // Held idle outside master mode, so a slave never times the bus itself.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n || !run)
        begin
            count <= 9'h000;
            phase <= PHASE_IDLE;
        end
        else
        begin
            unique case (phase)
                PHASE_IDLE:
                begin
                    count <= 9'h000;
                    phase <= PHASE_LOW;
                end
                PHASE_LOW:
                begin
                    count <= count + 9'h001;
                    if (count >= half_divisor - 9'h001)
                    begin
                        phase <= PHASE_HIGH;
                    end
                end
                PHASE_HIGH:
                begin
                    // A divisor written mid-period at or below the count ends the period at once
                    if (count >= divisor - 9'h001)
                    begin
                        count <= 9'h000;
                        phase <= PHASE_LOW;
                    end
                    else
                    begin
                        count <= count + 9'h001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            o_scl_tick <= 1'b0;
        end
        else
        begin
            o_scl_tick <= run && (phase == PHASE_HIGH) && (count >= divisor - 9'h001);
        end
    end

    // ************************************************************
    // Open-drain pins
    // ************************************************************
    // Outputs only ever pull low; high comes from the bus pull-ups.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            o_bus_drive <= 1'b0;
            o_scl_o <= 1'b0;
            o_scl_oe <= 1'b0;
            o_sda_o <= 1'b0;
            o_sda_oe <= 1'b0;
        end
        else
        begin
            o_bus_drive <= interface_enable;
            o_scl_o <= 1'b0;
            o_sda_o <= 1'b0;
            o_scl_oe <= interface_enable
                && ((run && phase == PHASE_LOW) || i_scl_hold_low);
            o_sda_oe <= interface_enable && i_sda_drive_low;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [8:0] tick_gap;
    logic [3:0] prev_select;
    logic gap_unsettled;

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            tick_gap <= 9'h000;
            prev_select <= 4'h0;
            gap_unsettled <= 1'b1;
        end
        else
        begin
            prev_select <= clock_select;
            if (o_scl_tick)
            begin
                tick_gap <= 9'h001;
            end
            else if (tick_gap != 9'h1ff)
            begin
                tick_gap <= tick_gap + 9'h001;
            end
            if (!run || clock_select != prev_select)
            begin
                gap_unsettled <= 1'b1;
            end
            else if (o_scl_tick)
            begin
                gap_unsettled <= 1'b0;
            end
        end
    end

    property p_halted_idle;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        !interface_enable |=> !o_scl_tick && !o_reception_start && !o_bus_drive;
    endproperty
    a_halted_idle: assert property (p_halted_idle)
        else $error("halted module still active");

    property p_enable_drive;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        interface_enable |=> o_bus_drive;
    endproperty
    a_enable_drive: assert property (p_enable_drive)
        else $error("enabled module not in bus drive state");

    property p_rx_restart;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_rx_data_read && interface_enable && !transmit_receive_select)
            |=> (o_reception_start == !$past(next_reception_disable))
                && (o_reception_refused == $past(next_reception_disable));
    endproperty
    a_rx_restart: assert property (p_rx_restart)
        else $error("next reception decision wrong");

    property p_mode_write;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (ctl_write && !i_arb_lost) |=> o_mode == $past(i_wdata[5:4]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode pair not taken from write");

    property p_arb_lost;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_arb_lost && master_slave_select) |=> o_mode == MODE_SLAVE_RX;
    endproperty
    a_arb_lost: assert property (p_arb_lost)
        else $error("arbitration loss did not enter slave receive");

    property p_slave_no_clock;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        !master_slave_select |=> !o_scl_tick && phase == PHASE_IDLE;
    endproperty
    a_slave_no_clock: assert property (p_slave_no_clock)
        else $error("serial clock runs in slave mode");

    property p_period_low_set;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (o_scl_tick && !gap_unsettled && !clock_select[3]) |-> tick_gap == divisor;
    endproperty
    a_period_low_set: assert property (p_period_low_set)
        else $error("serial clock period wrong, low set");

    property p_period_high_set;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (o_scl_tick && !gap_unsettled && clock_select[3]) |-> tick_gap == divisor;
    endproperty
    a_period_high_set: assert property (p_period_high_set)
        else $error("serial clock period wrong, high set");

    property p_halted_released;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        !interface_enable ##1 !interface_enable |-> !o_scl_oe && !o_sda_oe;
    endproperty
    a_halted_released: assert property (p_halted_released)
        else $error("halted module pulls a bus line low");

endmodule : i2c_control_mode_clock_select

`default_nettype wire

// >>> logic/i2c_ctl_pkg.sv
`default_nettype none

package i2c_ctl_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] BUS_CONTROL_A_OFFSET = 8'h00;
    localparam logic [7:0] BUS_CONTROL_A_RESET = 8'h00;

    // ************************************************************
    // Field positions of bus_control_a
    // ************************************************************
    localparam int INTERFACE_ENABLE_POS = 7;
    localparam int NEXT_RECEPTION_DISABLE_POS = 6;
    localparam int MASTER_SLAVE_SELECT_POS = 5;
    localparam int TRANSMIT_RECEIVE_SELECT_POS = 4;
    localparam int CLOCK_SELECT_LSB = 0;
    localparam int CLOCK_SELECT_MSB = 3;

    // ************************************************************
    // Operating modes, master/slave bit above transmit/receive bit
    // ************************************************************
    localparam logic [1:0] MODE_SLAVE_RX = 2'h0;
    localparam logic [1:0] MODE_SLAVE_TX = 2'h1;
    localparam logic [1:0] MODE_MASTER_RX = 2'h2;
    localparam logic [1:0] MODE_MASTER_TX = 2'h3;

    // ************************************************************
    // Serial clock divisors in system clock cycles, by select code
    // ************************************************************
    localparam logic [8:0] DIVISOR_TABLE [16] = '{
        9'h01c, 9'h028, 9'h030, 9'h040, 9'h0a8, 9'h064, 9'h070, 9'h080,
        9'h038, 9'h050, 9'h060, 9'h080, 9'h150, 9'h0c8, 9'h0e0, 9'h100
    };

    typedef enum logic [1:0] {
        PHASE_IDLE,
        PHASE_LOW,
        PHASE_HIGH
    } scl_phase_t;

endpackage : i2c_ctl_pkg

`default_nettype wire
